// >>> src/pulse_driver_status_error_regs.sv
// control/status word and two fault words of the pulsed diode driver
`include "driver_regs_consts.svh"
`default_nettype none
module pulse_driver_status_error_regs
  import driver_regs_pkg::*;
#(
  parameter int unsigned MIN_GAP_CYCLES = `TRIG_MIN_CYCLES
)(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command port from the text command parser
  input wire logic cmd_rd,
  input wire logic cmd_wr,
  input wire logic [1:0] cmd_sel,
  input wire logic [31:0] cmd_wdata,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  // pins
  input wire logic enable_pin,
  input wire logic interlock_a_pin,
  input wire logic interlock_b_pin,
  input wire logic ext_trigger_pin,
  // state from surrounding logic
  input wire logic calibration_active,
  input wire logic integral_term_off,
  input wire logic [5:0] crc_fault_in,
  input wire logic [4:0] misc_fault_one_in,
  input wire logic [7:0] sensor_fail_in,
  input wire logic [9:0] sensor_over_in,
  input wire logic [7:0] hottest_temp_c,
  input wire logic [31:0] misc_fault_two_in,
  input wire logic [1:0] overcurrent_in,
  input wire logic seq_done_in,
  // control outputs
  output logic [1:0] trigger_source_select,
  output logic [1:0] regulator_mode_select,
  output logic trigger_edge_select,
  output logic load_defaults_at_powerup,
  output logic channel_zero_use,
  output logic channel_one_use,
  output logic fan_auto,
  output logic ext_trigger_fire,
  output logic seq_start,
  output logic seq_abort,
  output logic pulse_output_on
);
  driver_ctl_if ctl ();

  logic [2:0] pin_meta_r;
  logic [2:0] pin_s_r;
  logic enable_s;
  logic interlock_s;
  logic interlock_a_s;
  logic interlock_b_s;
  logic enable_last_r;
  logic [1:0] startup_cnt_r;
  logic startup_done;
  logic lock_r;
  logic enabled_r;
  logic ack;
  logic healthy;
  logic [31:0] fault1_r;
  logic [31:0] fault2_r;
  logic [31:0] fault2_set;
  logic over_now;
  logic warn_now;
  logic cool_end;
  logic [31:0] status_word;
  logic st_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam logic [2:0] PIN_RST = 3'h0;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      pin_meta_r <= PIN_RST;
      pin_s_r <= PIN_RST;
    end
    else
    begin
      pin_meta_r <= {interlock_b_pin, interlock_a_pin, enable_pin};
      pin_s_r <= pin_meta_r;
    end

  assign enable_s = pin_s_r[0];
  assign interlock_a_s = pin_s_r[1];
  assign interlock_b_s = pin_s_r[2];
  assign interlock_s = interlock_a_s & interlock_b_s;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      enable_last_r <= 1'b0;
    else
      enable_last_r <= enable_s;

  // enable low on two samples acknowledges latched errors, so one stray low sample does not
  assign ack = ~enable_s & ~enable_last_r;

  ////////////////////////////////////////////////////////////////////////////////
  // startup capture: wait until the synchroniser holds real pin samples

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      startup_cnt_r <= 2'h0;
    else if (startup_cnt_r != `STARTUP_WAIT)
      startup_cnt_r <= startup_cnt_r + 2'h1;

  assign startup_done = (startup_cnt_r == `STARTUP_WAIT);

  ////////////////////////////////////////////////////////////////////////////////
  // writable control fields

  assign st_wr = cmd_wr && (cmd_sel == `SEL_STATUS);

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      load_defaults_at_powerup <= `RST_DEFAULTS;
      trigger_edge_select <= `RST_EDGE;
      trigger_source_select <= `RST_TRIG;
      regulator_mode_select <= `RST_REG;
      fan_auto <= `RST_FAN;
    end
    else if (st_wr)
    begin
      load_defaults_at_powerup <= cmd_wdata[`ST_DEFAULTS];
      trigger_edge_select <= cmd_wdata[`ST_EDGE];
      trigger_source_select <= cmd_wdata[`ST_TRIG_LO +: 2];
      regulator_mode_select <= cmd_wdata[`ST_REG_LO +: 2];
      fan_auto <= cmd_wdata[`ST_FAN];
    end

  // channel use bits silently keep their value outside calibration
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      channel_zero_use <= `RST_CH_USE;
      channel_one_use <= `RST_CH_USE;
    end
    else if (st_wr && calibration_active)
    begin
      channel_zero_use <= cmd_wdata[`ST_CH0];
      channel_one_use <= cmd_wdata[`ST_CH1];
    end

  ////////////////////////////////////////////////////////////////////////////////
  // temperature supervision

  assign over_now = (hottest_temp_c >= `TEMP_SHUTDOWN_C);
  assign warn_now = (hottest_temp_c >= (`TEMP_SHUTDOWN_C - `TEMP_WARN_MARGIN_C));
  assign cool_end = (hottest_temp_c < (`TEMP_SHUTDOWN_C - `TEMP_HYST_C));

  ////////////////////////////////////////////////////////////////////////////////
  // fault word one

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      fault1_r <= 32'h0;
    else
    begin
      fault1_r[5:0] <= crc_fault_in;
      fault1_r[6] <= over_now | (fault1_r[6] & ~ack);
      fault1_r[7] <= warn_now;
      // cooldown clears only by temperature, never by acknowledge
      fault1_r[8] <= over_now | (fault1_r[8] & ~cool_end);
      fault1_r[13:9] <= misc_fault_one_in | (fault1_r[13:9] & ~{5{ack}});
      fault1_r[21:14] <= sensor_fail_in;
      if (over_now && !fault1_r[8])
        fault1_r[31:22] <= sensor_over_in;
      else if (!fault1_r[8])
        fault1_r[31:22] <= 10'h0;
    end

  ////////////////////////////////////////////////////////////////////////////////
  // fault word two

  always_comb
  begin
    fault2_set = misc_fault_two_in & `F2_MISC_MASK;
    fault2_set[`F2_STARTUP] = (startup_cnt_r == (`STARTUP_WAIT - 2'h1)) & enable_s;
    fault2_set[`F2_RATE] = ctl.rate_evt;
    fault2_set[`F2_OCUR0] = overcurrent_in[0];
    fault2_set[`F2_OCUR1] = overcurrent_in[1];
    fault2_set[`F2_ILOCK_A] = enabled_r & ~interlock_a_s;
    fault2_set[`F2_ILOCK_B] = enabled_r & ~interlock_b_s;
  end

  // set wins over the acknowledge clear; unused bits never set
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      fault2_r <= 32'h0;
    else
      fault2_r <= (fault2_set | (fault2_r & ~{32{ack & startup_done}})) & `F2_USED_MASK;

  assign healthy = (fault1_r[31:8] == 24'h0) && (fault1_r[6:0] == 7'h0) && (fault2_r == 32'h0);

  ////////////////////////////////////////////////////////////////////////////////
  // lock and output enable

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      lock_r <= 1'b1;
    else if (!healthy || fault2_set[`F2_STARTUP])
      lock_r <= 1'b1;
    else if (!enable_s && startup_done)
      lock_r <= 1'b0;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      enabled_r <= 1'b0;
    else
      enabled_r <= enable_s & interlock_s & ~lock_r & healthy & startup_done;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      pulse_output_on <= 1'b0;
    else
      pulse_output_on <= enable_s & interlock_s & ~lock_r & healthy & enabled_r;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  assign ctl.edge_rising = trigger_edge_select;
  assign ctl.ext_armed = enabled_r && ((trigger_source_select == TRIG_EXTERNAL) ||
                                      (trigger_source_select == TRIG_EXT_CONTROLLED));
  assign ctl.sw_req = st_wr & cmd_wdata[`ST_SW_PULSE];
  assign ctl.sw_abort = st_wr & cmd_wdata[`ST_ABORT];
  assign ctl.sw_allowed = enabled_r && (trigger_source_select == TRIG_SOFTWARE);
  assign ctl.stop = ~enabled_r;
  assign ctl.done = seq_done_in;
  assign ext_trigger_fire = ctl.trig_fire;
  assign seq_start = ctl.seq_start;
  assign seq_abort = ctl.seq_abort;

  trigger_front #(
    .MIN_GAP_CYCLES(MIN_GAP_CYCLES)
  ) u_trig (
    .clk(clk),
    .rstn(rstn),
    .trig_pin(ext_trigger_pin),
    .ctl(ctl.trig)
  );

  sw_sequencer u_seq (
    .clk(clk),
    .rstn(rstn),
    .ctl(ctl.seq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read side

  always_comb
  begin
    status_word = 32'h0;
    status_word[`ST_ENABLE] = enable_s;
    status_word[`ST_ILOCK_A] = interlock_s;
    status_word[`ST_ILOCK_B] = interlock_s;
    status_word[`ST_HEALTHY] = healthy;
    status_word[`ST_DEFAULTS] = load_defaults_at_powerup;
    status_word[`ST_EDGE] = trigger_edge_select;
    status_word[`ST_TRIG_LO +: 2] = trigger_source_select;
    status_word[`ST_REG_LO +: 2] = regulator_mode_select;
    status_word[`ST_CAL] = calibration_active;
    status_word[`ST_LOCK] = lock_r;
    status_word[`ST_CH0] = channel_zero_use;
    status_word[`ST_CH1] = channel_one_use;
    status_word[`ST_ENABLED] = enabled_r;
    status_word[`ST_RUNNING] = ctl.running;
    status_word[`ST_FAN] = fan_auto;
    status_word[`ST_INTEGRAL] = integral_term_off;
  end

  // the stage-health bit of word two reads one when healthy
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= 32'h0;
    end
    else
    begin
      rsp_valid <= cmd_rd;
      if (cmd_rd)
        unique case (cmd_sel)
          `SEL_STATUS: rsp_data <= status_word;
          `SEL_FAULT_ONE: rsp_data <= fault1_r;
          `SEL_FAULT_TWO: rsp_data <= fault2_r ^ (32'h1 << `F2_HEALTH_LOW);
          default: rsp_data <= 32'h0;
        endcase
    end
endmodule // pulse_driver_status_error_regs
`default_nettype wire

// >>> src/driver_regs_consts.svh
// bit positions, reset values and timing counts of the driver status and fault register bank
//
// Behaviour
// - control word bits 7:6 pick trigger source: internal, external, ext-controlled, software.
// - control word bits 9:8 pick regulator mode, with optional capacitor-voltage tracking.
// - edge-select bit one means rising trigger edge, zero means falling edge.
// - writable bit asks for stored defaults at power-up instead of last configuration.
// - writing one to bit 18 starts a sequence only in software trigger mode.
// - read-only bit 19 shows a software sequence is running.
// - writing one to bit 20 stops the running software sequence.
// - read-only health bit reads zero once any error is present.
// - read-only bit 0 mirrors the enable pin level.
// - bits 1 and 2 both show the same interlock level.
// - lock bit holds device out of operation until enable pin goes low.
// - calibration flag; channel use bits writable only during calibration.
// - host-writable fan mode: zero manual speed, one temperature-driven speed.
// - read-only bit shows integral term off (one) or on (zero).
// - two 32-bit fault words, one marks an error or warning; word two bit 11 reads one when healthy.
// - fault word one flags checksum failures of defaults, config and per-channel calibrations.
// - warning 5 C below shutdown; cooldown flag until 10 C below maximum.
// - per-sensor failure bits 14-21, per-sensor shutdown source bits 22-31.
// - fault word two bit 0: enable already high at startup.
// - fault bit when external trigger repeats faster than allowed.
// - separate fault bits when either interlock input drops during operation.
// - separate fault bits for overcurrent on channel zero and channel one.
// - any error switches pulse output off; enable toggle acknowledges before re-enable.
`ifndef DRIVER_REGS_CONSTS_SVH
`define DRIVER_REGS_CONSTS_SVH

// word selectors on the command port
`define SEL_STATUS 2'h0
`define SEL_FAULT_ONE 2'h1
`define SEL_FAULT_TWO 2'h2

// control/status word bit positions
`define ST_ENABLE 0
`define ST_ILOCK_A 1
`define ST_ILOCK_B 2
`define ST_HEALTHY 3
`define ST_DEFAULTS 4
`define ST_EDGE 5
`define ST_TRIG_LO 6
`define ST_REG_LO 8
`define ST_CAL 10
`define ST_LOCK 11
`define ST_CH0 12
`define ST_CH1 13
`define ST_ENABLED 16
`define ST_SW_PULSE 18
`define ST_RUNNING 19
`define ST_ABORT 20
`define ST_FAN 22
`define ST_INTEGRAL 25

// control reset values
`define RST_DEFAULTS 1'b0
`define RST_EDGE 1'b1
`define RST_TRIG 2'h0
`define RST_REG 2'h0
`define RST_CH_USE 1'b1
`define RST_FAN 1'b0

// fault word two positions
`define F2_STARTUP 0
`define F2_RATE 3
`define F2_HEALTH_LOW 11
`define F2_OCUR0 15
`define F2_OCUR1 16
`define F2_ILOCK_A 19
`define F2_ILOCK_B 20
`define F2_MISC_MASK 32'h0006_7ff6
`define F2_USED_MASK 32'h001f_ffff

// temperature thresholds in degrees C
`define TEMP_SHUTDOWN_C 8'd80
`define TEMP_WARN_MARGIN_C 8'd5
`define TEMP_HYST_C 8'd10

// timing
`define CLK_MHZ 250
`define TRIG_MIN_PERIOD_US 1000
`define TRIG_MIN_CYCLES (`TRIG_MIN_PERIOD_US * `CLK_MHZ)
`define STARTUP_WAIT 2'h3

`endif

// >>> src/driver_regs_pkg.sv
// types shared by the driver register bank modules
`default_nettype none
package driver_regs_pkg;
  typedef enum logic [1:0] {TRIG_INTERNAL, TRIG_EXTERNAL, TRIG_EXT_CONTROLLED, TRIG_SOFTWARE} trig_src_t;
  typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;
endpackage
`default_nettype wire

// >>> src/driver_ctl_if.sv
// internal carrier between the register bank and its trigger and sequence helpers
`default_nettype none
interface driver_ctl_if;
  logic edge_rising;
  logic ext_armed;
  logic trig_fire;
  logic rate_evt;
  logic sw_req;
  logic sw_abort;
  logic sw_allowed;
  logic stop;
  logic done;
  logic running;
  logic seq_start;
  logic seq_abort;
  modport bank (output edge_rising, ext_armed, sw_req, sw_abort, sw_allowed, stop, done,
                input trig_fire, rate_evt, running, seq_start, seq_abort);
  modport trig (input edge_rising, ext_armed, output trig_fire, rate_evt);
  modport seq (input sw_req, sw_abort, sw_allowed, stop, done, output running, seq_start, seq_abort);
endinterface
`default_nettype wire

// >>> src/trigger_front.sv
// external trigger synchroniser, edge selection and repetition-rate check
`include "driver_regs_consts.svh"
`default_nettype none
module trigger_front
  import driver_regs_pkg::*;
#(
  parameter int unsigned MIN_GAP_CYCLES = `TRIG_MIN_CYCLES
)(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pin
  input wire logic trig_pin,
  // bank side
  driver_ctl_if.trig ctl
);
  logic [1:0] sync_r;
  logic last_r;
  logic edge_hit;
  logic [19:0] gap_r;
  logic seen_r;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      sync_r <= 2'h0;
      last_r <= 1'b0;
    end
    else
    begin
      sync_r <= {sync_r[0], trig_pin};
      last_r <= sync_r[1];
    end

  assign edge_hit = ctl.edge_rising ? (sync_r[1] & ~last_r) : (~sync_r[1] & last_r);

  // gap counter saturates so a long idle never wraps into a false rate fault
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      gap_r <= 20'h0;
      seen_r <= 1'b0;
    end
    else if (edge_hit)
    begin
      gap_r <= 20'h0;
      seen_r <= 1'b1;
    end
    else if (gap_r != 20'hf_ffff)
      gap_r <= gap_r + 20'h1;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      ctl.trig_fire <= 1'b0;
      ctl.rate_evt <= 1'b0;
    end
    else
    begin
      ctl.trig_fire <= edge_hit & ctl.ext_armed;
      ctl.rate_evt <= edge_hit & ctl.ext_armed & seen_r & ({12'h0, gap_r} < 32'(MIN_GAP_CYCLES - 1));
    end
endmodule // trigger_front
`default_nettype wire

// >>> src/sw_sequencer.sv
// software-triggered pulse sequence control: start, running state and abort
`include "driver_regs_consts.svh"
`default_nettype none
module sw_sequencer
  import driver_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bank side
  driver_ctl_if.seq ctl
);
  seq_state_t state_r;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      state_r <= SEQ_IDLE;
      ctl.seq_start <= 1'b0;
      ctl.seq_abort <= 1'b0;
    end
    else
    begin
      ctl.seq_start <= 1'b0;
      ctl.seq_abort <= 1'b0;
      unique case (state_r)
        SEQ_IDLE:
          if (ctl.sw_req && ctl.sw_allowed && !ctl.stop)
          begin
            state_r <= SEQ_RUN;
            ctl.seq_start <= 1'b1;
          end
        SEQ_RUN:
          if (ctl.sw_abort || ctl.stop)
          begin
            state_r <= SEQ_IDLE;
            ctl.seq_abort <= 1'b1;
          end
          else if (ctl.done)
            state_r <= SEQ_IDLE;
      endcase
    end

  assign ctl.running = (state_r == SEQ_RUN);
endmodule // sw_sequencer
`default_nettype wire

// >>> dv/driver_regs_asserts.sv
// port-level checker for the driver status and fault register bank
`default_nettype none
module driver_regs_asserts #(
  parameter int unsigned MIN_GAP_CYCLES = 50
)(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command port
  input wire logic cmd_rd,
  input wire logic cmd_wr,
  input wire logic [1:0] cmd_sel,
  input wire logic [31:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  // state and outputs
  input wire logic calibration_active,
  input wire logic [1:0] overcurrent_in,
  input wire logic [1:0] trigger_source_select,
  input wire logic [1:0] regulator_mode_select,
  input wire logic trigger_edge_select,
  input wire logic load_defaults_at_powerup,
  input wire logic channel_zero_use,
  input wire logic channel_one_use,
  input wire logic fan_auto,
  input wire logic ext_trigger_fire,
  input wire logic seq_start,
  input wire logic seq_abort,
  input wire logic pulse_output_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_rd(logic [1:0] s);
    cmd_rd && cmd_sel == s;
  endsequence
  property p_rsp; cmd_rd |=> rsp_valid; endproperty
  property p_rsp_one; !cmd_rd |=> !rsp_valid; endproperty
  property p_modes; cmd_wr && cmd_sel == 2'h0 |=> trigger_source_select == $past(cmd_wdata[7:6])
    && regulator_mode_select == $past(cmd_wdata[9:8]); endproperty
  property p_flags; cmd_wr && cmd_sel == 2'h0 |=> trigger_edge_select == $past(cmd_wdata[5])
    && load_defaults_at_powerup == $past(cmd_wdata[4]) && fan_auto == $past(cmd_wdata[22]); endproperty
  property p_ch_lock; !calibration_active && cmd_wr |=> $stable(channel_zero_use) && $stable(channel_one_use);
  endproperty
  property p_start; seq_start |-> trigger_source_select == 2'h3; endproperty
  property p_fire; ext_trigger_fire |-> trigger_source_select == 2'h1 || trigger_source_select == 2'h2;
  endproperty
  property p_off; overcurrent_in != 2'h0 |-> ##[1:3] !pulse_output_on; endproperty
  property p_ilock; s_rd(2'h0) |=> rsp_data[1] == rsp_data[2]; endproperty
  property p_resv; s_rd(2'h0) |=> (rsp_data & 32'hfdb6c000) == 32'h0; endproperty
  property p_resv2; s_rd(2'h2) |=> rsp_data[31:21] == 11'h0; endproperty
  property p_sel3; s_rd(2'h3) |=> rsp_data == 32'h0; endproperty
  a_rsp: assert property (p_rsp) else $error("no answer after read");
  a_rsp_one: assert property (p_rsp_one) else $error("answer without read");
  a_modes: assert property (p_modes) else $error("mode fields not written");
  a_flags: assert property (p_flags) else $error("control flags not written");
  a_ch_lock: assert property (p_ch_lock) else $error("channel use changed outside calibration");
  a_start: assert property (p_start) else $error("sequence start outside software mode");
  a_fire: assert property (p_fire) else $error("trigger fired in wrong mode");
  a_off: assert property (p_off) else $error("output still on after overcurrent");
  a_ilock: assert property (p_ilock) else $error("interlock bits differ");
  a_resv: assert property (p_resv) else $error("reserved status bit set");
  a_resv2: assert property (p_resv2) else $error("reserved fault bit set");
  a_sel3: assert property (p_sel3) else $error("unused selector not zero");
  c_start: cover property (seq_start);
  c_abort: cover property (seq_abort);
  c_fire: cover property (ext_trigger_fire);
endmodule // driver_regs_asserts
bind pulse_driver_status_error_regs driver_regs_asserts #(.MIN_GAP_CYCLES(MIN_GAP_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data), .calibration_active(calibration_active),
  .overcurrent_in(overcurrent_in), .trigger_source_select(trigger_source_select),
  .regulator_mode_select(regulator_mode_select), .trigger_edge_select(trigger_edge_select),
  .load_defaults_at_powerup(load_defaults_at_powerup), .channel_zero_use(channel_zero_use),
  .channel_one_use(channel_one_use), .fan_auto(fan_auto), .ext_trigger_fire(ext_trigger_fire),
  .seq_start(seq_start), .seq_abort(seq_abort), .pulse_output_on(pulse_output_on));
`default_nettype wire

// >>> dv/host_model.sv
// host side of the text command link: word reads and writes
`default_nettype none
module host_model (
  // clock
  input wire logic clk,
  // command
  output logic cmd_rd,
  output logic cmd_wr,
  output logic [1:0] cmd_sel,
  output logic [31:0] cmd_wdata,
  // answer
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cmd_rd = 1'b0;
    cmd_wr = 1'b0;
    cmd_sel = 2'h0;
    cmd_wdata = 32'h0;
  end
  task wr(input logic [1:0] s, input logic [31:0] d);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_sel = s;
    cmd_wdata = d;
    @(negedge clk);
    cmd_wr = 1'b0;
    // idle data shows the inverse so a stale copy cannot pass
    cmd_wdata = ~d;
  endtask
  task rd(input logic [1:0] s, output logic [31:0] q, output logic v);
    @(negedge clk);
    cmd_rd = 1'b1;
    cmd_sel = s;
    @(negedge clk);
    cmd_rd = 1'b0;
    v = rsp_valid;
    q = rsp_data;
  endtask
endmodule // host_model
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the driver status and fault register bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, cmd_rd, cmd_wr, rsp_valid, enable_pin = 1'b1, ila = 1'b1, ilb = 1'b1;
  logic trig = 1'b0, cal = 1'b0, ioff = 1'b0, done = 1'b0;
  logic [1:0] cmd_sel, oc = 2'h0, trg, rgm;
  logic [31:0] cmd_wdata, rsp_data, q;
  logic [5:0] crc = 6'h0;
  logic [7:0] sfail = 8'h0, temp = 8'd25;
  logic [9:0] sover = 10'h0;
  logic edg, defs, ch0, ch1, fan, fire, sst, sab, pon;
  bit s_st, s_ab, s_fi;
  int error_cnt = 0, compares = 0, cyc = 0;
  always #2 clk = ~clk;
  host_model host (.clk(clk), .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  pulse_driver_status_error_regs #(.MIN_GAP_CYCLES(50)) uut (.clk(clk), .rstn(rstn), .cmd_rd(cmd_rd),
    .cmd_wr(cmd_wr), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .enable_pin(enable_pin), .interlock_a_pin(ila), .interlock_b_pin(ilb), .ext_trigger_pin(trig),
    .calibration_active(cal), .integral_term_off(ioff), .crc_fault_in(crc), .misc_fault_one_in(5'h0),
    .sensor_fail_in(sfail), .sensor_over_in(sover), .hottest_temp_c(temp), .misc_fault_two_in(32'h0),
    .overcurrent_in(oc), .seq_done_in(done), .trigger_source_select(trg), .regulator_mode_select(rgm),
    .trigger_edge_select(edg), .load_defaults_at_powerup(defs), .channel_zero_use(ch0),
    .channel_one_use(ch1), .fan_auto(fan), .ext_trigger_fire(fire), .seq_start(sst), .seq_abort(sab),
    .pulse_output_on(pon));
  ////////////////////////////////////////////////////////////////////////////
  task conclude;
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude;
    end
  end
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task rs(input logic [1:0] s, output logic [31:0] d);
    logic v;
    host.rd(s, d, v);
    chk("rsp_valid", 32'(v), 32'h1);
  endtask
  task mon(input int n);
    // a strobe launched by the write just before stands only at entry
    s_st = sst;
    s_ab = sab;
    s_fi = fire;
    repeat (n)
    begin
      @(negedge clk);
      s_st |= sst;
      s_ab |= sab;
      s_fi |= fire;
    end
  endtask
  // enable low then high acknowledges sticky faults
  task ack;
    @(negedge clk);
    enable_pin = 1'b0;
    repeat (8) @(negedge clk);
    enable_pin = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_startup;
    repeat (10) @(negedge clk);
    rs(2'h2, q);
    chk("fault2 start", q, 32'h801);
    rs(2'h0, q);
    chk("status locked", q, 32'h3827);
    chk("pon locked", 32'(pon), 32'h0);
    ack();
    rs(2'h0, q);
    chk("status run", q, 32'h1302f);
    rs(2'h1, q);
    chk("fault1 clean", q, 32'h0);
    chk("pon", 32'(pon), 32'h1);
  endtask
  task t_ctrl;
    logic [31:0] d;
    for (int i = 0; i < 4; i++)
    begin
      d = 32'hfc000000 | (i << 6) | ((3 - i) << 8) | (i[0] << 5) | (i[1] << 4) | (i[0] << 22);
      host.wr(2'h0, d);
      chk("trig", 32'(trg), 32'(i));
      chk("regm", 32'(rgm), 32'(3 - i));
      chk("edge/defs/fan", {edg, defs, fan}, {i[0], i[1], i[0]});
      chk("ch use", {ch0, ch1}, 2'h3);
      rs(2'h0, q);
      chk("status rb", q, 32'h1300f | (d & 32'h004003f0));
    end
    host.wr(2'h1, 32'hffffffff);
    rs(2'h1, q);
    chk("fault1 ro", q, 32'h0);
    rs(2'h3, q);
    chk("sel3", q, 32'h0);
  endtask
  task t_cal;
    cal = 1'b1;
    host.wr(2'h0, 32'h20);
    chk("ch cal", {ch0, ch1}, 2'h0);
    rs(2'h0, q);
    chk("status cal", q, 32'h1042f);
    host.wr(2'h0, 32'h3020);
    cal = 1'b0;
    ioff = 1'b1;
    rs(2'h0, q);
    chk("integral", q[25], 1'b1);
    ioff = 1'b0;
  endtask
  task t_sw;
    host.wr(2'h0, 32'h40020);
    mon(6);
    chk("start mode0", 32'(s_st), 32'h0);
    // the request counts only once software mode already stands
    host.wr(2'h0, 32'he0);
    host.wr(2'h0, 32'h400e0);
    mon(6);
    chk("start mode3", 32'(s_st), 32'h1);
    rs(2'h0, q);
    chk("running", q[19:18], 2'h2);
    host.wr(2'h0, 32'h1000e0);
    mon(6);
    chk("abort", 32'(s_ab), 32'h1);
    rs(2'h0, q);
    chk("stopped", q[20:19], 2'h0);
    host.wr(2'h0, 32'h400e0);
    @(negedge clk) done = 1'b1;
    @(negedge clk) done = 1'b0;
    mon(4);
    rs(2'h0, q);
    chk("done idle", q[19], 1'b0);
  endtask
  task t_ext;
    host.wr(2'h0, 32'h40);
    @(negedge clk) trig = 1'b1;
    mon(8);
    chk("rise ignored", 32'(s_fi), 32'h0);
    @(negedge clk) trig = 1'b0;
    mon(8);
    chk("fall fired", 32'(s_fi), 32'h1);
    host.wr(2'h0, 32'h60);
    // let the gap since the last accepted edge pass the minimum
    repeat (60) @(negedge clk);
    @(negedge clk) trig = 1'b1;
    mon(8);
    chk("rise fired", 32'(s_fi), 32'h1);
    rs(2'h2, q);
    chk("rate ok", q, 32'h800);
    trig = 1'b0;
    repeat (4) @(negedge clk);
    trig = 1'b1;
    mon(8);
    rs(2'h2, q);
    chk("rate fast", q, 32'h808);
    trig = 1'b0;
    ack();
  endtask
  task t_flt;
    logic [31:0] e[4] = '{32'h8800, 32'h10800, 32'h80800, 32'h100800};
    for (int k = 0; k < 4; k++)
    begin
      @(negedge clk);
      if (k < 2) oc = 2'(k + 1);
      else {ila, ilb} = (k == 2) ? 2'h1 : 2'h2;
      @(negedge clk) oc = 2'h0;
      repeat (6) @(negedge clk);
      {ila, ilb} = 2'h3;
      chk("pon off", 32'(pon), 32'h0);
      rs(2'h2, q);
      chk("fault2", q, e[k]);
      rs(2'h0, q);
      chk("health/lock", q & 32'h10808, 32'h800);
      ack();
    end
    crc = 6'h3f;
    sfail = 8'ha5;
    repeat (3) @(negedge clk);
    rs(2'h1, q);
    chk("crc/sensor", q, 32'h29403f);
    crc = 6'h0;
    sfail = 8'h0;
    temp = 8'd76;
    repeat (3) @(negedge clk);
    rs(2'h1, q);
    chk("warn", q, 32'h80);
    sover = 10'h1;
    temp = 8'd81;
    repeat (3) @(negedge clk);
    temp = 8'd72;
    repeat (3) @(negedge clk);
    rs(2'h1, q);
    chk("cooling", q, 32'h400140);
    temp = 8'd65;
    sover = 10'h0;
    ack();
    rs(2'h1, q);
    chk("cooled", q, 32'h0);
    chk("pon back", 32'(pon), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    t_startup();
    t_ctrl();
    t_cal();
    t_sw();
    t_ext();
    t_flt();
    conclude();
  end
endmodule // tb
`default_nettype wire
